/* common/break_chan_c_map.vh */
`ifndef BREAK_CHAN_C_MAP_VH
`define BREAK_CHAN_C_MAP_VH
// ****************************************
// register word offsets
// ****************************************
`define OFS_ADDR_HIGH 4'h0
`define OFS_ADDR_LOW 4'h1
`define OFS_MASK_HIGH 4'h2
`define OFS_MASK_LOW 4'h3
`define OFS_CYCLE_QUAL 4'h4
`define OFS_STATUS 4'h5
`define OFS_ENABLE 4'h6
`define OFS_CLEAR 4'h7
// ****************************************
// field positions and reset values
// ****************************************
`define XY_ENABLE_BIT 9
`define XY_SELECT_BIT 8
`define QUAL_WRITE_MASK 16'h03FF
`define HALF_RESET 16'h0000
`define UNMAPPED_READ 32'h00000000
`endif

/* design/break_chan_c_addr_match.v */
// The implementer's own choices: register access over Avalon-MM and the address map.
`include "break_chan_c_map.vh"
`timescale 1ns/1ns
`default_nettype none
module break_chan_c_addr_match #(
  parameter ADDR_W = 32,
  parameter XY_W = 16
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // avalon-mm slave, word addressed
  input wire [3:0] address_i,
  input wire read_i,
  input wire write_i,
  input wire [31:0] writedata_i,
  output reg [31:0] readdata_o,
  output reg waitrequest_o,
  // watched buses
  input wire [ADDR_W-1:0] main_address_bus_i,
  input wire main_cycle_valid_i,
  input wire [XY_W-1:0] x_memory_address_bus_i,
  input wire x_cycle_valid_i,
  input wire [XY_W-1:0] y_memory_address_bus_i,
  input wire y_cycle_valid_i,
  // to qualifier and interrupt logic
  output reg addr_match_o,
  output reg xy_bus_enable_o,
  output reg xy_bus_select_o,
  output reg irq_o
);

  // ****************************************
  // registers
  // ****************************************
  reg [15:0] break_addr_c_high;
  reg [15:0] break_addr_c_low;
  reg [15:0] break_addr_mask_c_high;
  reg [15:0] break_addr_mask_c_low;
  reg [15:0] chan_c_cycle_qualifier_reg;
  reg status;
  reg irq_enable;
  reg busy;
  reg next_match;
  reg [31:0] next_readdata;
  wire [31:0] chan_c_match_address;
  wire [31:0] chan_c_match_mask;
  wire xy_bus_enable;
  wire xy_bus_select;
  wire main_hit;
  wire x_hit;
  wire y_hit;
  wire access;
  wire ack;
  wire write_ack;
  wire clear_hit;

  // ****************************************
  // address and mask views
  // ****************************************
  assign chan_c_match_address = {break_addr_c_high, break_addr_c_low};
  assign chan_c_match_mask = {break_addr_mask_c_high, break_addr_mask_c_low};
  assign xy_bus_enable = chan_c_cycle_qualifier_reg[`XY_ENABLE_BIT];
  assign xy_bus_select = chan_c_cycle_qualifier_reg[`XY_SELECT_BIT];

  // ****************************************
  // comparators
  // ****************************************
  // mask bit 1 drops the bit, 0 keeps it
  masked_compare #(
    .W(ADDR_W)
  ) main_cmp (
    .bus_i(main_address_bus_i),
    .ref_i(chan_c_match_address[ADDR_W-1:0]),
    .mask_i(chan_c_match_mask[ADDR_W-1:0]),
    .hit_o(main_hit)
  );

  // bit 0 left out: x/y accesses are always words
  masked_compare #(
    .W(15)
  ) x_cmp (
    .bus_i(x_memory_address_bus_i[15:1]),
    .ref_i(break_addr_c_high[15:1]),
    .mask_i(break_addr_mask_c_high[15:1]),
    .hit_o(x_hit)
  );

  masked_compare #(
    .W(15)
  ) y_cmp (
    .bus_i(y_memory_address_bus_i[15:1]),
    .ref_i(break_addr_c_low[15:1]),
    .mask_i(break_addr_mask_c_low[15:1]),
    .hit_o(y_hit)
  );

  // ****************************************
  // bus selection
  // ****************************************
  // unselected buses never reach the match, even when they hit
  always @* begin
    next_match = 1'b0;
    case ({xy_bus_enable, xy_bus_select})
      2'h0: begin
        next_match = main_cycle_valid_i & main_hit;
      end
      2'h1: begin
        next_match = main_cycle_valid_i & main_hit;
      end
      2'h2: begin
        next_match = x_cycle_valid_i & x_hit;
      end
      2'h3: begin
        next_match = y_cycle_valid_i & y_hit;
      end
      default: begin
        next_match = 1'b0;
      end
    endcase
  end

  // ****************************************
  // bus handshake
  // ****************************************
  // one wait cycle so read data comes from a flop
  assign access = (read_i | write_i) & ~busy;
  // writes land only at the edge the master sees waitrequest low
  assign ack = busy & ~waitrequest_o;
  assign write_ack = ack & write_i;
  assign clear_hit = write_ack & (address_i == `OFS_CLEAR) & writedata_i[0];

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      waitrequest_o <= 1'b1;
    end else begin
      busy <= access;
      waitrequest_o <= ~access;
    end
  end

  // ****************************************
  // writable registers
  // ****************************************
  // synchronous reset on rst_i, which also reinitialises the registers when asserted mid-run
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      break_addr_c_high <= `HALF_RESET;
    end else if (write_ack && address_i == `OFS_ADDR_HIGH) begin
      break_addr_c_high <= writedata_i[15:0];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      break_addr_c_low <= `HALF_RESET;
    end else if (write_ack && address_i == `OFS_ADDR_LOW) begin
      break_addr_c_low <= writedata_i[15:0];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      break_addr_mask_c_high <= `HALF_RESET;
    end else if (write_ack && address_i == `OFS_MASK_HIGH) begin
      break_addr_mask_c_high <= writedata_i[15:0];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      break_addr_mask_c_low <= `HALF_RESET;
    end else if (write_ack && address_i == `OFS_MASK_LOW) begin
      break_addr_mask_c_low <= writedata_i[15:0];
    end
  end

  // outputs written with the register so they never lag the compare
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      chan_c_cycle_qualifier_reg <= `HALF_RESET;
      xy_bus_enable_o <= 1'b0;
      xy_bus_select_o <= 1'b0;
    end else if (write_ack && address_i == `OFS_CYCLE_QUAL) begin
      chan_c_cycle_qualifier_reg <= writedata_i[15:0] & `QUAL_WRITE_MASK;
      xy_bus_enable_o <= writedata_i[`XY_ENABLE_BIT];
      xy_bus_select_o <= writedata_i[`XY_SELECT_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_enable <= 1'b0;
    end else if (write_ack && address_i == `OFS_ENABLE) begin
      irq_enable <= writedata_i[0];
    end
  end

  // ****************************************
  // status
  // ****************************************
  // set wins over clear, so no event is lost
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      status <= 1'b0;
    end else if (next_match) begin
      status <= 1'b1;
    end else if (clear_hit) begin
      status <= 1'b0;
    end
  end

  // ****************************************
  // readback
  // ****************************************
  always @* begin
    next_readdata = `UNMAPPED_READ;
    case (address_i)
      `OFS_ADDR_HIGH: begin
        next_readdata = {16'h0000, break_addr_c_high};
      end
      `OFS_ADDR_LOW: begin
        next_readdata = {16'h0000, break_addr_c_low};
      end
      `OFS_MASK_HIGH: begin
        next_readdata = {16'h0000, break_addr_mask_c_high};
      end
      `OFS_MASK_LOW: begin
        next_readdata = {16'h0000, break_addr_mask_c_low};
      end
      `OFS_CYCLE_QUAL: begin
        next_readdata = {16'h0000, chan_c_cycle_qualifier_reg};
      end
      `OFS_STATUS: begin
        next_readdata = {31'h00000000, status};
      end
      `OFS_ENABLE: begin
        next_readdata = {31'h00000000, irq_enable};
      end
      default: begin
        next_readdata = `UNMAPPED_READ;
      end
    endcase
  end

  // loaded at the taken edge, stands when waitrequest goes low
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      readdata_o <= `UNMAPPED_READ;
    end else if (access && read_i) begin
      readdata_o <= next_readdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_match_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      addr_match_o <= next_match;
      irq_o <= (status | next_match) & irq_enable;
    end
  end

endmodule // break_chan_c_addr_match

// ****************************************
// masked compare
// ****************************************
module masked_compare #(
  parameter W = 16
) (
  // compared words
  input wire [W-1:0] bus_i,
  input wire [W-1:0] ref_i,
  // 1 drops a bit from the compare
  input wire [W-1:0] mask_i,
  // result
  output wire hit_o
);
  assign hit_o = ~|((bus_i ^ ref_i) & ~mask_i);
endmodule // masked_compare
`default_nettype wire

/* sim/break_chan_c_addr_match_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// port checks
// ****
module break_chan_c_checker (
  input wire logic core_clk_i, rst_i, read_i, write_i, waitrequest_o,
  input wire logic [31:0] readdata_o,
  input wire logic main_cycle_valid_i, x_cycle_valid_i, y_cycle_valid_i,
  input wire logic addr_match_o, xy_bus_enable_o, xy_bus_select_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_idle; !main_cycle_valid_i && !x_cycle_valid_i && !y_cycle_valid_i; endsequence
  a_wait_one: assert property ($fell(waitrequest_o) |=> waitrequest_o) else $error("wait");
  a_ack_bound: assert property ((read_i || write_i) |-> ##[0:2] !waitrequest_o) else $error("ack");
  a_read_upper: assert property (read_i && !waitrequest_o |-> readdata_o[31:16] == 16'h0000) else $error("up");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=> waitrequest_o && !addr_match_o) else $error("rst");
  a_main_idle: assert property (!xy_bus_enable_o && !main_cycle_valid_i |=> !addr_match_o) else $error("m");
  a_x_only: assert property (xy_bus_enable_o && !xy_bus_select_o && !x_cycle_valid_i |=> !addr_match_o) else $error("x");
  a_y_only: assert property (xy_bus_enable_o && xy_bus_select_o && !y_cycle_valid_i |=> !addr_match_o) else $error("y");
  a_match_idle: assert property (s_idle |=> !addr_match_o) else $error("idle");
endmodule // break_chan_c_checker
bind break_chan_c_addr_match break_chan_c_checker chk (.*);
`default_nettype wire

/* sim/break_chan_c_addr_match_tb.sv */
`include "break_chan_c_map.vh"
`timescale 1ns/1ns
`default_nettype none
module break_chan_c_addr_match_tb;
  logic core_clk_i = 0, rst_i = 1, read_i = 0, write_i = 0, waitrequest_o, addr_match_o, xy_en, xy_sel, irq_o;
  logic [3:0] address_i = 4'h0;
  logic [31:0] writedata_i = 32'h0, readdata_o, q, main_a;
  logic [15:0] x_a, y_a;
  logic [2:0] valid;
  int fails = 0, checked = 0;
  // mode, bus, mask, value, match
  logic [68:0] rows [9] = '{{2'h0,2'h0,32'h0,32'hABCD5678,1'h1}, {2'h0,2'h0,32'h0,32'h2BCD5678,1'h0},
    {2'h0,2'h0,32'h80000000,32'h2BCD5678,1'h1}, {2'h2,2'h1,32'h0,32'hABCC,1'h1}, {2'h2,2'h1,32'h0,32'hABCF,1'h0},
    {2'h2,2'h1,32'h20000,32'hABCF,1'h1}, {2'h3,2'h2,32'h0,32'h5679,1'h1}, {2'h3,2'h2,32'hFFFF0000,32'h5670,1'h0},
    {2'h2,2'h2,32'h0,32'hABCD,1'h0}};
  always #10 core_clk_i = ~core_clk_i;
  cpu_bus_model bus (.core_clk_i, .main_a, .x_a, .y_a, .valid);
  break_chan_c_addr_match dut (.core_clk_i, .rst_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
    .waitrequest_o, .main_address_bus_i(main_a), .main_cycle_valid_i(valid[0]), .x_memory_address_bus_i(x_a),
    .x_cycle_valid_i(valid[1]), .y_memory_address_bus_i(y_a), .y_cycle_valid_i(valid[2]), .addr_match_o,
    .xy_bus_enable_o(xy_en), .xy_bus_select_o(xy_sel), .irq_o);
  task chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    {read_i, write_i, address_i, writedata_i} <= {!w, w, a, d};
    @(posedge core_clk_i);
    while (waitrequest_o !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk_i);
    end
    if (n == 20) fails++;
    q = readdata_o;
    {read_i, write_i} <= 2'h0;
  endtask
  task end_of_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000 fails++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 0;
    for (int i = 0; i < 5; i++) begin
      acc(0, i[3:0], 32'h0);
      chk(q, `HALF_RESET);
    end
    acc(1, `OFS_ADDR_HIGH, 32'hABCD);
    acc(1, `OFS_ADDR_LOW, 32'h5678);
    acc(0, `OFS_ADDR_HIGH, 32'h0);
    chk(q, 32'hABCD);
    acc(1, `OFS_ENABLE, 32'h1);
    foreach (rows[i]) begin
      acc(1, `OFS_CYCLE_QUAL, {22'h0, rows[i][68:67], 8'h00});
      acc(1, `OFS_MASK_HIGH, {16'h0, rows[i][64:49]});
      acc(1, `OFS_MASK_LOW, {16'h0, rows[i][48:33]});
      bus.cyc(rows[i][66:65], rows[i][32:1]);
      @(posedge core_clk_i);
      chk(addr_match_o, rows[i][0]);
      chk(xy_en, rows[i][68]);
      chk(xy_sel, rows[i][67]);
      $display("row %0d done", i);
    end
    chk(irq_o, 1'b1);
    acc(1, `OFS_CLEAR, 32'h1);
    acc(0, `OFS_STATUS, 32'h0);
    chk(q, 32'h0);
    chk(irq_o, 1'b0);
    acc(1, `OFS_ENABLE, 32'h0);
    bus.cyc(2'h1, 32'hABCD);
    acc(0, `OFS_STATUS, 32'h0);
    chk(q, 32'h1);
    chk(irq_o, 1'b0);
    acc(0, 4'hF, 32'h0);
    chk(q, `UNMAPPED_READ);
    $display("interrupt and map done");
    rst_i <= 1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 0;
    acc(0, `OFS_ADDR_HIGH, 32'h0);
    chk(q, `HALF_RESET);
    chk(xy_en, 1'b0);
    $display("mid-run reset done");
    end_of_test;
  end
endmodule // break_chan_c_addr_match_tb
`default_nettype wire

/* sim/cpu_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// cpu and x/y buses
// ****
module cpu_bus_model (
  input wire logic core_clk_i,
  output logic [31:0] main_a,
  output logic [15:0] x_a,
  output logic [15:0] y_a,
  output logic [2:0] valid
);
  initial {main_a, x_a, y_a, valid} = 67'h0;
  // released buses show inverse, never stale value
  task cyc(input logic [1:0] b, input logic [31:0] a);
    @(posedge core_clk_i);
    valid <= 3'h1 << b;
    {main_a, x_a, y_a} <= {a, a[15:0], a[15:0]};
    @(posedge core_clk_i);
    valid <= 3'h0;
    {main_a, x_a, y_a} <= ~{a, a[15:0], a[15:0]};
  endtask
endmodule // cpu_bus_model
`default_nettype wire
